// ==== logic/bbf_duty_if.sv ====
// Carrier between the PWM duty meter and the brightness top.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface bbf_duty_if;
  logic pwm_level;
  logic [10:0] duty_code;
  logic duty_update;
  modport meter (input pwm_level, output duty_code, output duty_update);
  modport user (output pwm_level, input duty_code, input duty_update);
endinterface

// ==== logic/bbf_pkg.sv ====
// Constants, types and helpers of the backlight brightness and boost
// frequency block. Assumes a 50 MHz clock; shared by the meter and the top.
package bbf_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] ADDR_BOOST_CONTROL = 8'h13;
  localparam logic [7:0] ADDR_HIGH_THRESHOLD = 8'h15;
  localparam logic [7:0] ADDR_LOW_THRESHOLD = 8'h16;
  localparam logic [7:0] ADDR_BRIGHTNESS_LOW = 8'h18;
  localparam logic [7:0] ADDR_BRIGHTNESS_HIGH = 8'h19;

  // Field positions in boost control
  localparam int MIN_INDUCTOR_BIT = 4;
  localparam int FREQ_SELECT_BIT = 5;
  localparam int FREQ_SHIFT_BIT = 6;

  // Values after reset
  localparam logic [7:0] RST_BOOST_CONTROL = 8'h00;
  localparam logic [7:0] RST_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_BRIGHTNESS_HIGH = 8'h00;
  localparam logic [2:0] RST_BRIGHTNESS_LOW = 3'h0;
  localparam logic [10:0] RST_CODE = 11'h000;

  // ************************************************************
  // Code widths and timing
  // ************************************************************
  localparam int CODE_W = 11;
  localparam logic [10:0] CODE_MAX = 11'h7ff;
  localparam int CLOCK_MHZ = 50;
  localparam int RAMP_BASE_NS = 125000;
  localparam int RAMP_BASE_CYCLES = (RAMP_BASE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int PWM_SAMPLE_NS = 1250;
  localparam int PWM_SAMPLE_CYCLES = (PWM_SAMPLE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int PWM_WINDOW_SAMPLES = 2047;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_BUS = 2'h0,
    MODE_PWM = 2'h1,
    MODE_MULT_RAMP = 2'h2,
    MODE_RAMP_MULT = 2'h3
  } bbf_mode_type;

  typedef enum logic [1:0] {
    FREQ_250K = 2'h0,
    FREQ_500K = 2'h1,
    FREQ_1M = 2'h3
  } bbf_freq_type;

  typedef enum logic {
    RAMP_IDLE = 1'b0,
    RAMP_RUN = 1'b1
  } bbf_ramp_type;

  // Scale a code by a duty code; full duty passes the code unchanged
  function automatic logic [10:0] bbf_scale(input logic [10:0] code,
                                            input logic [10:0] duty);
    logic [21:0] prod;
    prod = 22'(code) * 22'(duty);
    if (duty == CODE_MAX) begin
      return code;
    end
    return prod[21:11];
  endfunction

endpackage

// ==== logic/bbf_pwm_meter.sv ====
// PWM duty meter: counts high samples over a fixed window of samples.
// Assumes pwm_level is already synchronised to clock.
`timescale 1ns/1ps
module bbf_pwm_meter #(
  parameter int SAMPLE_CYCLES = bbf_pkg::PWM_SAMPLE_CYCLES,
  parameter int WINDOW_SAMPLES = bbf_pkg::PWM_WINDOW_SAMPLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Duty carrier
  bbf_duty_if.meter duty
);

  logic [11:0] div_count, next_div_count;
  logic [10:0] win_count, next_win_count;
  logic [10:0] high_count, next_high_count;
  logic [10:0] duty_code, next_duty_code;
  logic duty_update, next_duty_update;

  // ************************************************************
  // Sampling and window count
  // ************************************************************
  // A window of 2047 samples gives the code directly, no divider needed;
  // the PWM period must be well under the window for a steady reading
  always_comb begin
    next_div_count = div_count;
    next_win_count = win_count;
    next_high_count = high_count;
    next_duty_code = duty_code;
    next_duty_update = 1'b0;
    if (div_count == 12'(SAMPLE_CYCLES - 1)) begin
      next_div_count = 12'h000;
      if (win_count == 11'(WINDOW_SAMPLES - 1)) begin
        next_win_count = 11'h000;
        next_duty_code = high_count + 11'(duty.pwm_level);
        next_high_count = 11'h000;
        next_duty_update = 1'b1;
      end else begin
        next_win_count = win_count + 11'h001;
        next_high_count = high_count + 11'(duty.pwm_level);
      end
    end else begin
      next_div_count = div_count + 12'h001;
    end
  end

  // Registers of the meter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_count <= 12'h000;
      win_count <= 11'h000;
      high_count <= 11'h000;
      duty_code <= bbf_pkg::RST_CODE;
      duty_update <= 1'b0;
    end else begin
      div_count <= next_div_count;
      win_count <= next_win_count;
      high_count <= next_high_count;
      duty_code <= next_duty_code;
      duty_update <= next_duty_update;
    end
  end

  assign duty.duty_code = duty_code;
  assign duty.duty_update = duty_update;

endmodule

// ==== logic/bbf_top.sv ====
// Brightness path and boost frequency selection of a dual-string
// backlight driver. Registers arrive as decoded byte accesses from a
// two-wire bus slave on the same clock; the PWM pin is asynchronous.
`timescale 1ns/1ps
module bbf_top #(
  parameter int RAMP_BASE_CYC = bbf_pkg::RAMP_BASE_CYCLES,
  parameter int SAMPLE_CYCLES = bbf_pkg::PWM_SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register access port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  // Brightness control settings
  input wire logic [1:0] brightness_mode,
  input wire logic [2:0] ramp_rate_sel,
  // PWM dimming pin
  input wire logic pwm_in,
  // Analog side controls
  output logic [10:0] led_sink_current,
  output logic [1:0] boost_freq,
  output logic freq_shift,
  output logic max_boost_duty,
  output logic min_inductor_large,
  output logic ramp_busy
);

  // ************************************************************
  // Reset and pin synchronisers
  // ************************************************************
  logic rst_meta, rst_n;
  logic pwm_meta, pwm_sync;

  // Release of reset passes two flops, assertion is immediate
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // PWM pin to clock domain; only the second flop is read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pwm_meta <= 1'b0;
      pwm_sync <= 1'b0;
    end else begin
      pwm_meta <= pwm_in;
      pwm_sync <= pwm_meta;
    end
  end

  // ************************************************************
  // Duty meter
  // ************************************************************
  bbf_duty_if duty_bus ();
  assign duty_bus.pwm_level = pwm_sync;

  bbf_pwm_meter #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .WINDOW_SAMPLES(bbf_pkg::PWM_WINDOW_SAMPLES)
  ) u_meter (
    .clock(clock),
    .rst_n(rst_n),
    .duty(duty_bus.meter)
  );

  // ************************************************************
  // Register file
  // ************************************************************
  logic [7:0] boost_control, next_boost_control;
  logic [7:0] auto_freq_high_threshold, next_auto_freq_high_threshold;
  logic [7:0] auto_freq_low_threshold, next_auto_freq_low_threshold;
  logic [2:0] brightness_low_bits, next_brightness_low_bits;
  logic [7:0] brightness_high_bits, next_brightness_high_bits;
  logic [10:0] brightness_code, next_brightness_code;
  logic [7:0] next_reg_rd_data;
  logic next_reg_rd_valid;

  // Writes store fields; the target moves only on the high-bits write
  always_comb begin
    next_boost_control = boost_control;
    next_auto_freq_high_threshold = auto_freq_high_threshold;
    next_auto_freq_low_threshold = auto_freq_low_threshold;
    next_brightness_low_bits = brightness_low_bits;
    next_brightness_high_bits = brightness_high_bits;
    next_brightness_code = brightness_code;
    if (reg_wr_en) begin
      unique case (reg_addr)
        bbf_pkg::ADDR_BOOST_CONTROL: begin
          next_boost_control = reg_wr_data;
        end
        bbf_pkg::ADDR_HIGH_THRESHOLD: begin
          next_auto_freq_high_threshold = reg_wr_data;
        end
        bbf_pkg::ADDR_LOW_THRESHOLD: begin
          next_auto_freq_low_threshold = reg_wr_data;
        end
        bbf_pkg::ADDR_BRIGHTNESS_LOW: begin
          // Held aside until the high bits arrive
          next_brightness_low_bits = reg_wr_data[2:0];
        end
        bbf_pkg::ADDR_BRIGHTNESS_HIGH: begin
          next_brightness_high_bits = reg_wr_data;
          next_brightness_code = {reg_wr_data, brightness_low_bits};
        end
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
  end

  // Read data is registered; unmapped addresses and the unused brightness low bits read zero, boost control reads back whole
  always_comb begin
    next_reg_rd_valid = reg_rd_en;
    next_reg_rd_data = 8'h00;
    if (reg_rd_en) begin
      unique case (reg_addr)
        bbf_pkg::ADDR_BOOST_CONTROL: begin
          next_reg_rd_data = boost_control;
        end
        bbf_pkg::ADDR_HIGH_THRESHOLD: begin
          next_reg_rd_data = auto_freq_high_threshold;
        end
        bbf_pkg::ADDR_LOW_THRESHOLD: begin
          next_reg_rd_data = auto_freq_low_threshold;
        end
        bbf_pkg::ADDR_BRIGHTNESS_LOW: begin
          next_reg_rd_data = {5'h00, brightness_low_bits};
        end
        bbf_pkg::ADDR_BRIGHTNESS_HIGH: begin
          next_reg_rd_data = brightness_high_bits;
        end
        default: begin
          next_reg_rd_data = 8'h00;
        end
      endcase
    end
  end

  // Register file state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      boost_control <= bbf_pkg::RST_BOOST_CONTROL;
      auto_freq_high_threshold <= bbf_pkg::RST_THRESHOLD;
      auto_freq_low_threshold <= bbf_pkg::RST_THRESHOLD;
      brightness_low_bits <= bbf_pkg::RST_BRIGHTNESS_LOW;
      brightness_high_bits <= bbf_pkg::RST_BRIGHTNESS_HIGH;
      brightness_code <= bbf_pkg::RST_CODE;
      reg_rd_data <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      boost_control <= next_boost_control;
      auto_freq_high_threshold <= next_auto_freq_high_threshold;
      auto_freq_low_threshold <= next_auto_freq_low_threshold;
      brightness_low_bits <= next_brightness_low_bits;
      brightness_high_bits <= next_brightness_high_bits;
      brightness_code <= next_brightness_code;
      reg_rd_data <= next_reg_rd_data;
      reg_rd_valid <= next_reg_rd_valid;
    end
  end

  // ************************************************************
  // Ramper target selection
  // ************************************************************
  bbf_pkg::bbf_mode_type mode;
  logic [10:0] duty_code;
  logic [10:0] ramp_target;

  assign mode = bbf_pkg::bbf_mode_type'(brightness_mode);
  assign duty_code = duty_bus.duty_code;

  // Mode decides which source feeds the ramper
  always_comb begin
    ramp_target = brightness_code;
    unique case (mode)
      bbf_pkg::MODE_BUS: begin
        ramp_target = brightness_code;
      end
      bbf_pkg::MODE_PWM: begin
        ramp_target = duty_code;
      end
      bbf_pkg::MODE_MULT_RAMP: begin
        ramp_target = bbf_pkg::bbf_scale(brightness_code, duty_code);
      end
      bbf_pkg::MODE_RAMP_MULT: begin
        ramp_target = brightness_code;
      end
    endcase
  end

  // ************************************************************
  // Ramper
  // ************************************************************
  bbf_pkg::bbf_ramp_type ramp_state, next_ramp_state;
  logic [10:0] ramp_code, next_ramp_code;
  logic [23:0] ramp_timer, next_ramp_timer;
  logic [23:0] step_cycles;
  logic [10:0] stepped_code;

  // Eight rates, each doubling the base step time
  assign step_cycles = 24'(RAMP_BASE_CYC) << ramp_rate_sel;
  assign stepped_code = (ramp_target > ramp_code) ? ramp_code + 11'h001
                                                  : ramp_code - 11'h001;

  // First step is taken at once, later ones one step time apart, so a
  // move of n codes lasts (n - 1) step times
  always_comb begin
    next_ramp_state = ramp_state;
    next_ramp_code = ramp_code;
    next_ramp_timer = ramp_timer;
    if (ramp_timer != 24'h000000) begin
      next_ramp_timer = ramp_timer - 24'h000001;
    end
    unique case (ramp_state)
      bbf_pkg::RAMP_IDLE: begin
        if (ramp_target != ramp_code) begin
          next_ramp_code = stepped_code;
          next_ramp_timer = step_cycles - 24'h000001;
          next_ramp_state = bbf_pkg::RAMP_RUN;
        end
      end
      bbf_pkg::RAMP_RUN: begin
        if (ramp_timer == 24'h000000) begin
          if (ramp_target == ramp_code) begin
            next_ramp_state = bbf_pkg::RAMP_IDLE;
          end else begin
            next_ramp_code = stepped_code;
            next_ramp_timer = step_cycles - 24'h000001;
          end
        end
      end
    endcase
  end

  // Ramper state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ramp_state <= bbf_pkg::RAMP_IDLE;
      ramp_code <= bbf_pkg::RST_CODE;
      ramp_timer <= 24'h000000;
    end else begin
      ramp_state <= next_ramp_state;
      ramp_code <= next_ramp_code;
      ramp_timer <= next_ramp_timer;
    end
  end

  // ************************************************************
  // Frequency selection
  // ************************************************************
  bbf_pkg::bbf_freq_type freq_choice;
  logic auto_mode;
  logic [10:0] next_led_sink_current;

  // Any non-zero threshold turns auto mode on
  assign auto_mode = (auto_freq_high_threshold != 8'h00) ||
                     (auto_freq_low_threshold != 8'h00);

  // Low threshold is tested first, so a low above high still gives 250k
  always_comb begin
    if (boost_control[bbf_pkg::FREQ_SELECT_BIT]) begin
      freq_choice = bbf_pkg::FREQ_1M;
    end else begin
      freq_choice = bbf_pkg::FREQ_500K;
    end
    if (auto_mode) begin
      if (brightness_high_bits < auto_freq_low_threshold) begin
        freq_choice = bbf_pkg::FREQ_250K;
      end else if (brightness_high_bits >= auto_freq_high_threshold) begin
        freq_choice = bbf_pkg::FREQ_1M;
      end else begin
        freq_choice = bbf_pkg::FREQ_500K;
      end
    end
  end

  // Mode 11 scales after the ramper, so duty changes act at once
  always_comb begin
    next_led_sink_current = ramp_code;
    if (mode == bbf_pkg::MODE_RAMP_MULT) begin
      next_led_sink_current = bbf_pkg::bbf_scale(ramp_code, duty_code);
    end
  end

  // ************************************************************
  // Output registers
  // ************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      led_sink_current <= bbf_pkg::RST_CODE;
      boost_freq <= bbf_pkg::FREQ_500K;
      freq_shift <= 1'b0;
      max_boost_duty <= 1'b0;
      min_inductor_large <= 1'b0;
      ramp_busy <= 1'b0;
    end else begin
      led_sink_current <= next_led_sink_current;
      boost_freq <= freq_choice;
      freq_shift <= boost_control[bbf_pkg::FREQ_SHIFT_BIT];
      // Half duty limit follows the lowest frequency only
      max_boost_duty <= (freq_choice == bbf_pkg::FREQ_250K);
      // Host-chosen inductor setting passed to the loop
      min_inductor_large <= boost_control[bbf_pkg::MIN_INDUCTOR_BIT];
      ramp_busy <= (next_ramp_state == bbf_pkg::RAMP_RUN);
    end
  end

endmodule

// ==== sim/bbf_pwm_src.sv ====
// Dimming source on the far side of the PWM pin.
// Free running on the bench clock; a period is 16 cycles.
`timescale 1ns/1ps
module bbf_pwm_src (
  // Clock
  input wire logic clock,
  // Duty as high cycles out of 16
  input wire logic [4:0] high_cycles,
  // PWM pin
  output logic pwm_level
);
  // ************************************************************
  // Period counter
  // ************************************************************
  logic [3:0] phase = 4'h0;
  logic [3:0] next_phase;

  always_comb begin
    next_phase = phase + 4'h1;
  end

  always_ff @(posedge clock) begin
    phase <= next_phase;
  end

  // A count of 16 holds the pin high, so full duty needs no edge
  assign pwm_level = {1'b0, phase} < high_cycles;
endmodule

// ==== sim/bbf_tb_top.sv ====
// Self-checking bench of the brightness and boost frequency block.
// Drives the decoded register port and a PWM source model.
`timescale 1ns/1ps
module bbf_tb_top;
  // ************************************************************
  // Signals, clock and instances
  // ************************************************************
  localparam int BASE = 4;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wr_data = 8'h00;
  logic [7:0] reg_rd_data;
  logic reg_rd_valid;
  logic [1:0] brightness_mode = 2'h0;
  logic [2:0] ramp_rate_sel = 3'h0;
  logic [4:0] pwm_high = 5'h10;
  logic pwm_in;
  logic [10:0] led_sink_current;
  logic [1:0] boost_freq;
  logic freq_shift;
  logic max_boost_duty;
  logic min_inductor_large;
  logic ramp_busy;
  logic [10:0] tgt;
  logic [7:0] ra [6] = '{8'h13, 8'h15, 8'h16, 8'h18, 8'h19, 8'h20};
  int err_count = 0;
  int n_tests = 0;
  int wc;

  always #10 clock = ~clock;

  // Short base step so every ramp rate fits the run
  bbf_top #(.RAMP_BASE_CYC(BASE), .SAMPLE_CYCLES(1)) i_bbf_top (
    .clock(clock), .nrst(nrst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .brightness_mode(brightness_mode), .ramp_rate_sel(ramp_rate_sel),
    .pwm_in(pwm_in), .led_sink_current(led_sink_current),
    .boost_freq(boost_freq), .freq_shift(freq_shift),
    .max_boost_duty(max_boost_duty),
    .min_inductor_large(min_inductor_large), .ramp_busy(ramp_busy));

  bbf_pwm_src i_bbf_pwm_src (.clock(clock), .high_cycles(pwm_high),
    .pwm_level(pwm_in));

  // ************************************************************
  // Tasks
  // ************************************************************
  task conclude;
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [10:0] s, input logic [10:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clock);
    reg_wr_en <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    @(negedge clock);
    chk("rd_valid", 11'(reg_rd_valid), 11'h1);
    chk("rd_data", 11'(reg_rd_data), 11'(e));
  endtask

  task setm(input logic [1:0] m);
    @(posedge clock);
    brightness_mode <= m;
  endtask

  // Bounded wait until the code equals, or leaves, a value
  task wait_led(input logic [10:0] e, input logic leave, input int b);
    wc = 0;
    while (leave ? led_sink_current === e : led_sink_current !== e) begin
      @(negedge clock);
      wc++;
      if (wc > b) begin
        err_count++;
        $display("ERROR wait_led expected %h seen %h", e, led_sink_current);
        conclude();
      end
    end
  endtask

  // Bounded wait until the ramper has settled; a move started while the
  // last step time still runs would begin late
  task wait_idle;
    wc = 0;
    while (ramp_busy !== 1'b0) begin
      @(negedge clock);
      wc++;
      if (wc > 5000) begin
        err_count++;
        $display("ERROR wait_idle expected 0 seen %h", ramp_busy);
        conclude();
      end
    end
  endtask

  task fcase(input logic [7:0] bc, input logic [7:0] lo,
             input logic [7:0] hi, input logic [1:0] f);
    wr(8'h13, bc);
    wr(8'h16, lo);
    wr(8'h15, hi);
    repeat (3) @(negedge clock);
    chk("boost_freq", 11'(boost_freq), 11'(f));
    chk("duty_limit", 11'(max_boost_duty), 11'(f == 2'h0));
    chk("freq_shift", 11'(freq_shift), 11'(bc[6]));
    chk("inductor", 11'(min_inductor_large), 11'(bc[4]));
    rd(8'h13, bc);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(negedge clock);
    chk("freq_reset", 11'(boost_freq), 11'h1);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], 8'h00);
    end
    // Bus path with the PWM pin held high
    wr(8'h18, 8'h05);
    rd(8'h18, 8'h05);
    chk("low_only", led_sink_current, 11'h000);
    wr(8'h19, 8'h02);
    wait_led(11'h015, 1'b0, 400);
    chk("bus_code", led_sink_current, 11'h015);
    // Every step rate over a three code move, each from a settled ramper
    for (int s = 0; s < 8; s++) begin
      tgt = (s % 2 == 0) ? 11'h018 : 11'h015;
      wait_idle();
      @(posedge clock);
      ramp_rate_sel <= 3'(s);
      wr(8'h18, {5'h00, tgt[2:0]});
      wr(8'h19, tgt[10:3]);
      wait_led(tgt, 1'b0, 5000);
      chk("ramp_min", 11'(wc >= 2 * (BASE << s)), 11'h1);
      chk("ramp_max", 11'(wc <= 2 * (BASE << s) + 4), 11'h1);
    end
    @(posedge clock);
    ramp_rate_sel <= 3'h0;
    // Brightness modes
    setm(2'h1);
    wait_led(11'h7ff, 1'b0, 20000);
    chk("pwm_only", led_sink_current, 11'h7ff);
    wr(8'h19, 8'h01);
    repeat (20) @(negedge clock);
    chk("bus_ignored", led_sink_current, 11'h7ff);
    setm(2'h2);
    wait_led(11'h00d, 1'b0, 20000);
    chk("mult_ramp", led_sink_current, 11'h00d);
    setm(2'h3);
    repeat (3) @(negedge clock);
    chk("ramp_mult", led_sink_current, 11'h00d);
    @(posedge clock);
    pwm_high <= 5'h00;
    // First window after the pin drops is partial; the next one reads zero
    wait_led(11'h00d, 1'b1, 6000);
    chk("no_ramp", 11'(ramp_busy), 11'h000);
    wait_led(11'h000, 1'b0, 6000);
    chk("duty_zero", led_sink_current, 11'h000);
    setm(2'h2);
    wr(8'h19, 8'h02);
    wait_led(11'h000, 1'b0, 400);
    chk("mult_zero", led_sink_current, 11'h000);
    setm(2'h0);
    wait_led(11'h015, 1'b0, 400);
    chk("bus_again", led_sink_current, 11'h015);
    // Frequency selection with high bits at 0x02
    fcase(8'h20, 8'h00, 8'h00, 2'h3);
    fcase(8'h40, 8'h00, 8'h00, 2'h1);
    fcase(8'h10, 8'h03, 8'h00, 2'h0);
    fcase(8'h00, 8'h02, 8'h08, 2'h1);
    fcase(8'h00, 8'h00, 8'h02, 2'h3);
    fcase(8'h20, 8'h01, 8'h09, 2'h1);
    fcase(8'h00, 8'h00, 8'h00, 2'h1);
    conclude();
  end
endmodule

// ==== sim/bbf_top_sva.sv ====
// Port checker of the brightness and boost frequency block.
// Bound into bbf_top; sees only its ports, one clock domain.
`timescale 1ns/1ps
module bbf_top_sva #(
  parameter int RAMP_BASE_CYC = 4,
  parameter int SAMPLE_CYCLES = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register access
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_valid,
  // Controls and outputs
  input wire logic [1:0] brightness_mode,
  input wire logic [10:0] led_sink_current,
  input wire logic [1:0] boost_freq,
  input wire logic freq_shift,
  input wire logic max_boost_duty,
  input wire logic min_inductor_large,
  input wire logic ramp_busy
);
  // ************************************************************
  // Helpers and assertions
  // ************************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  logic [10:0] prev_led;
  logic [10:0] gap;
  logic [10:0] next_gap;
  logic bus_mode;
  assign bus_mode = brightness_mode == 2'h0;

  // Cycles since the code last moved; saturates so idle never wraps
  always_comb begin
    next_gap = (gap == 11'h7ff) ? gap : gap + 11'h1;
    if (led_sink_current != prev_led) begin
      next_gap = 11'h000;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prev_led <= 11'h000;
      gap <= 11'h7ff;
    end else begin
      prev_led <= led_sink_current;
      gap <= next_gap;
    end
  end

  a_step_spacing: assert property (bus_mode && $past(bus_mode) &&
    led_sink_current != prev_led |-> gap >= RAMP_BASE_CYC - 1)
    else $error("ramp stepped faster than the base step time");
  a_single_step: assert property (bus_mode && $past(bus_mode) |->
    led_sink_current == prev_led || led_sink_current == prev_led + 11'h1
    || led_sink_current == prev_led - 11'h1)
    else $error("ramp moved more than one code");
  a_low_no_apply: assert property (reg_wr_en && reg_addr == 8'h18 &&
    !ramp_busy && bus_mode && $past(bus_mode) |=> !ramp_busy)
    else $error("low bits write started a ramp");
  a_high_apply: assert property (reg_wr_en && reg_addr == 8'h19 &&
    !ramp_busy && bus_mode && $past(bus_mode)
    && reg_wr_data != led_sink_current[10:3] |-> ##[1:2] ramp_busy)
    else $error("high bits write did not start a ramp");
  a_shift_follow: assert property (reg_wr_en && reg_addr == 8'h13
    |-> ##2 freq_shift == $past(reg_wr_data[6], 2))
    else $error("shift flag does not follow boost control");
  a_inductor_follow: assert property (reg_wr_en && reg_addr == 8'h13
    |-> ##2 min_inductor_large == $past(reg_wr_data[4], 2))
    else $error("inductor flag does not follow boost control");
  a_duty_limit: assert property (max_boost_duty == (boost_freq == 2'h0))
    else $error("duty limit not tied to lowest frequency");
  a_freq_code: assert property (boost_freq != 2'h2)
    else $error("unknown frequency code");
  a_read_pulse: assert property (reg_rd_en |=>
    reg_rd_valid ##1 !reg_rd_valid)
    else $error("read valid not a one cycle pulse");

  // Main scenarios reached
  c_pwm_full: cover property (brightness_mode == 2'h1
    && led_sink_current == 11'h7ff);
  c_low_freq: cover property (max_boost_duty);
  c_ramp: cover property ($rose(ramp_busy));
endmodule

bind bbf_top bbf_top_sva #(.RAMP_BASE_CYC(RAMP_BASE_CYC),
  .SAMPLE_CYCLES(SAMPLE_CYCLES)) i_bbf_top_sva (
  .clock(clock), .nrst(nrst), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
  .reg_rd_valid(reg_rd_valid), .brightness_mode(brightness_mode),
  .led_sink_current(led_sink_current), .boost_freq(boost_freq),
  .freq_shift(freq_shift), .max_boost_duty(max_boost_duty),
  .min_inductor_large(min_inductor_large), .ramp_busy(ramp_busy));
